// ### logic/flash_otp_ctrl.sv
// serial flash protection decoder and security-page command logic
`timescale 1ns/1ps

module flash_otp_ctrl #(
   parameter int ERASE_CYCLES   = flash_otp_pkg::OTP_ERASE_CYCLES,
   parameter int PROGRAM_CYCLES = flash_otp_pkg::OTP_PROGRAM_CYCLES
) (
   // system clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   // serial link pins
   input  wire logic        i_sclk,
   input  wire logic        i_cs_n,
   input  wire logic        i_si,
   input  wire logic        i_wp_n,
   output      logic        o_so,
   output      logic        o_so_oe_n,
   // main array protection query
   input  wire logic [19:0] i_check_addr,
   output      logic        o_array_protected,
   // status view
   output      logic        o_busy,
   output      logic        o_write_enable,
   output      logic [2:0]  o_otp_lock
);

   ////////////////////////////////////////////////////////////////////////////
   // link domain: command shifter on the serial clock

   logic        first_q;               // no edge seen yet in this frame
   logic [2:0]  bit_q;                 // bits taken in the current byte
   logic [8:0]  byte_q;                // whole bytes taken, saturating
   logic [6:0]  shift_q;               // partial byte
   logic [7:0]  opcode_q;              // first byte of the frame
   logic [23:0] addr_q;                // bytes one to three
   logic [9:0]  rd_addr_q;             // security read pointer
   logic [7:0]  wptr_q;                // page buffer write pointer
   logic [255:0] pmask_q;              // buffer bytes loaded by the last program frame
   logic [7:0]  pbuf [0:255];          // shared page buffer
   logic [7:0]  sec_mem [0:1023];      // security pages, page n at n*256
   logic        so_q;                  // serial output bit
   logic        drive_q;               // output driven in this frame
   logic [15:0] stat_s1_q;             // status bytes, first sync stage
   logic [15:0] stat_s2_q;             // status bytes, second sync stage
   logic        frame_tog_q;           // flips at the first edge of every frame
   logic [15:0] status_word;           // status bytes as kept in the system domain

   wire [2:0] cur_bit   = first_q ? 3'h0 : bit_q;
   wire [8:0] cur_byte  = first_q ? 9'h000 : byte_q;
   wire [7:0] byte_in   = {shift_q, i_si};
   wire       byte_done = (cur_bit == 3'h7);
   wire       is_read   = (opcode_q == flash_otp_pkg::OP_OTP_READ);
   wire       is_prog   = (opcode_q == flash_otp_pkg::OP_OTP_PROGRAM);
   wire       load_buf  = byte_done && is_prog && (cur_byte >= flash_otp_pkg::OTP_DATA_FIRST);

   // frame start marker, set while chip select is high
   always_ff @(posedge i_sclk or negedge i_rst_n or posedge i_cs_n) begin
      if (!i_rst_n || i_cs_n) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   // counters keep their values after release so the sequencer can judge the frame
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_q   <= 3'h0;
         byte_q  <= 9'h000;
         shift_q <= 7'h00;
         frame_tog_q <= 1'b0;
      end else begin
         // marks a frame that really carried clock edges
         frame_tog_q <= frame_tog_q ^ first_q;
         bit_q   <= cur_bit + 3'h1;
         shift_q <= byte_in[6:0];
         byte_q  <= (byte_done && cur_byte != 9'h1ff) ? cur_byte + 9'h001 : cur_byte;
      end
   end

   // opcode, address and read pointer capture
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         opcode_q  <= 8'h00;
         addr_q    <= 24'h000000;
         rd_addr_q <= 10'h000;
         wptr_q    <= 8'h00;
      end else if (byte_done) begin
         case (cur_byte)
            9'h000: opcode_q <= byte_in;
            9'h001: addr_q[23:16] <= byte_in;
            9'h002: addr_q[15:8] <= byte_in;
            9'h003: begin
               addr_q[7:0] <= byte_in;
               rd_addr_q   <= {addr_q[9:8], byte_in};
               wptr_q      <= byte_in;
            end
            default: begin
               // ten-bit pointer rolls 3ffh to 000h on its own, no gap
               if (is_read && cur_byte >= flash_otp_pkg::OTP_READ_FIRST) begin
                  rd_addr_q <= rd_addr_q + 10'h001;
               end
               if (load_buf) begin
                  wptr_q <= wptr_q + 8'h01;
               end
            end
         endcase
      end
   end

   // loaded-byte mask, cleared only when a program opcode arrives
   // a status poll during apply must not wipe the mask being applied
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pmask_q <= '0;
      end else if (byte_done && cur_byte == 9'h000
                   && byte_in == flash_otp_pkg::OP_OTP_PROGRAM) begin
         pmask_q <= '0;
      end else if (load_buf) begin
         pmask_q[wptr_q] <= 1'b1;
      end
   end

   // program data overwrites the page buffer, wrapping inside it
   always_ff @(posedge i_sclk) begin
      if (load_buf) begin
         pbuf[wptr_q] <= byte_in;
      end
   end

   // status bytes brought over bit by bit; each bit is an independent flag
   always_ff @(negedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_s1_q <= 16'h0000;
         stat_s2_q <= 16'h0000;
      end else begin
         stat_s1_q <= status_word;
         stat_s2_q <= stat_s1_q;
      end
   end

   // output selection for the falling edge
   wire       rd_st1   = (opcode_q == flash_otp_pkg::OP_READ_STATUS1);
   wire       rd_st2   = (opcode_q == flash_otp_pkg::OP_READ_STATUS2);
   wire [2:0] out_idx  = 3'h7 - bit_q;
   wire [7:0] mem_byte = sec_mem[rd_addr_q];
   wire       rd_data  = is_read && (byte_q >= flash_otp_pkg::OTP_READ_FIRST);
   wire       rd_stat  = (rd_st1 || rd_st2) && (byte_q != 9'h000);
   wire [7:0] stat_sel = rd_st1 ? stat_s2_q[15:8] : stat_s2_q[7:0];
   wire       next_so  = rd_data ? mem_byte[out_idx] : stat_sel[out_idx];

   // shifted out on the falling edge; release clears the driver at once
   always_ff @(negedge i_sclk or negedge i_rst_n or posedge i_cs_n) begin
      if (!i_rst_n || i_cs_n) begin
         so_q    <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         so_q    <= next_so;
         drive_q <= !first_q && (rd_data || rd_stat);
      end
   end

   assign o_so      = so_q;
   // the raw pin takes part so a release mid-byte floats the line without a clock
   assign o_so_oe_n = i_cs_n || !drive_q;

   ////////////////////////////////////////////////////////////////////////////
   // system domain: pin synchronisers

   logic [2:0] cs_sync_q;              // chip select, two stages plus edge
   logic [1:0] wp_sync_q;              // write-protect pin

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_sync_q <= 3'h7;
         wp_sync_q <= 2'h3;
      end else begin
         cs_sync_q <= {cs_sync_q[1:0], i_cs_n};
         wp_sync_q <= {wp_sync_q[0], i_wp_n};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // system domain: frame decode at release
   // link registers are read only after release, when the serial clock is still

   flash_otp_pkg::nv_state_t state_q;  // sequencer state
   logic [5:0]  prot_q;                // protect, gran, top/bottom, range
   logic        cmp_q;                 // complement
   logic [2:0]  lock_q;                // page lock bits
   logic        wel_q;                 // write-enable latch
   logic        busy_q;                // busy flag
   logic        erase_q;               // current operation is erase
   logic [1:0]  page_q;                // target page 1..3
   logic [7:0]  idx_q;                 // byte index while applying
   logic [23:0] timer_q;               // self-timed wait
   logic        prot_out_q;            // registered protection answer
   logic        frame_used_q;          // frame marker already judged

   wire        cs_rise   = cs_sync_q[1] && !cs_sync_q[2];
   // a release with no clock edge inside must not replay the previous frame
   wire        fresh     = frame_tog_q != frame_used_q;
   wire        frame_end = cs_rise && fresh;
   wire        wp_low    = !wp_sync_q[1];
   // the release sets first_q again, so only the bit count is judged here
   wire        aligned   = (bit_q == 3'h0);
   wire        cmd_ok    = frame_end && aligned && !busy_q;
   wire [7:0]  page_byte = addr_q[15:8];
   wire        page_hit  = (addr_q[23:16] == flash_otp_pkg::OTP_HIGH_BYTE)
                           && (page_byte >= flash_otp_pkg::OTP_FIRST_PAGE)
                           && (page_byte <= flash_otp_pkg::OTP_LAST_PAGE);
   wire [1:0]  page_sel  = page_byte[1:0];
   wire        page_lock = lock_q[page_sel - 2'h1];
   wire        op_wren   = cmd_ok && byte_q == 9'h001
                           && opcode_q == flash_otp_pkg::OP_WRITE_ENABLE;
   wire        op_wrdi   = cmd_ok && byte_q == 9'h001
                           && opcode_q == flash_otp_pkg::OP_WRITE_DISABLE;
   wire        is_wrsr   = frame_end && !busy_q && wel_q
                           && opcode_q == flash_otp_pkg::OP_WRITE_STATUS;
   wire        wrsr_ok   = is_wrsr && aligned && !wp_low
                           && (byte_q == 9'h002 || byte_q == 9'h003);
   wire        is_erase  = frame_end && !busy_q && wel_q
                           && opcode_q == flash_otp_pkg::OP_OTP_ERASE;
   // anything but release exactly after the last address bit aborts
   wire        erase_go  = is_erase && aligned && byte_q == flash_otp_pkg::OTP_ADDR_BYTES
                           && page_hit && !page_lock;
   wire        is_prog_c = frame_end && !busy_q && wel_q && is_prog;
   wire        prog_go   = is_prog_c && aligned && page_hit && !page_lock
                           && byte_q > flash_otp_pkg::OTP_DATA_FIRST;
   wire        nv_abort  = (is_erase && !erase_go) || (is_prog_c && !prog_go);
   wire        nv_start  = erase_go || prog_go;
   wire        nv_done   = (state_q == flash_otp_pkg::ST_WAIT) && timer_q == 24'h000000;
   wire [7:0]  sr1_new   = addr_q[23:16];
   wire [7:0]  sr2_new   = addr_q[15:8];

   // status word as the serial reader sees it
   assign status_word = {prot_q, wel_q, busy_q,
                         1'b0, cmp_q, lock_q, 3'h0};

   // remember the frame marker of every release, judged or not
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         frame_used_q <= 1'b0;
      end else if (cs_rise) begin
         frame_used_q <= frame_tog_q;
      end
   end

   // write-enable latch: set, cleared by disable, abort, status write or completion
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wel_q <= 1'b0;
      end else if (op_wren) begin
         wel_q <= 1'b1;
      end else if (op_wrdi || nv_abort || wrsr_ok || nv_done) begin
         wel_q <= 1'b0;
      end
   end

   // protection and lock bits move only through an accepted status write
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prot_q <= flash_otp_pkg::PROT_BITS_RESET;
         cmp_q  <= flash_otp_pkg::CMP_RESET;
         lock_q <= flash_otp_pkg::LOCK_RESET;
      end else if (wrsr_ok) begin
         prot_q <= sr1_new[7:2];
         if (byte_q == 9'h003) begin
            cmp_q  <= sr2_new[flash_otp_pkg::S2_CMP];
            // a lock bit can be set but never cleared
            lock_q <= lock_q | sr2_new[5:3];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // system domain: self-timed sequencer

   wire [9:0]  mem_addr = {page_q, idx_q};
   wire [7:0]  prog_val = sec_mem[mem_addr] & pbuf[idx_q];  // flash only clears bits
   wire [23:0] wait_len = erase_q ? ERASE_CYCLES[23:0] : PROGRAM_CYCLES[23:0];

   // idle, apply one byte per cycle, then wait out the cell time
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= flash_otp_pkg::ST_IDLE;
         busy_q  <= 1'b0;
         erase_q <= 1'b0;
         page_q  <= 2'h0;
         idx_q   <= 8'h00;
         timer_q <= 24'h000000;
      end else begin
         unique case (state_q)
            flash_otp_pkg::ST_IDLE: if (nv_start) begin
               state_q <= flash_otp_pkg::ST_APPLY;
               busy_q  <= 1'b1;
               erase_q <= erase_go;
               page_q  <= page_sel;
               idx_q   <= 8'h00;
            end
            flash_otp_pkg::ST_APPLY: begin
               idx_q <= idx_q + 8'h01;
               if (idx_q == 8'hff) begin
                  state_q <= flash_otp_pkg::ST_WAIT;
                  timer_q <= wait_len - 24'h000001;
               end
            end
            flash_otp_pkg::ST_WAIT: begin
               timer_q <= timer_q - 24'h000001;
               if (nv_done) begin
                  state_q <= flash_otp_pkg::ST_IDLE;
                  busy_q  <= 1'b0;
               end
            end
         endcase
      end
   end

   // erase fills the page, program ands the loaded buffer bytes into it
   // plain always: the factory preset below writes the same array
   always @(posedge i_clock) begin
      if (state_q == flash_otp_pkg::ST_APPLY) begin
         if (erase_q) begin
            sec_mem[mem_addr] <= flash_otp_pkg::ERASED_BYTE;
         end else if (pmask_q[idx_q]) begin
            sec_mem[mem_addr] <= prog_val;
         end
      end
   end

   // blank parts leave the factory erased
   initial begin
      for (int i = 0; i < 1024; i++) begin
         sec_mem[i] = flash_otp_pkg::ERASED_BYTE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // main array protection decoder, for array program and erase only

   wire [2:0] range_code = prot_q[2:0];
   wire       gran       = prot_q[4];
   wire       top_bot    = prot_q[3];
   wire [8:0] blk        = {1'b0, i_check_addr[19:flash_otp_pkg::BLOCK_LSB]};
   wire       all_code   = gran ? (range_code[2:1] == 2'b11) : (range_code >= 3'h5);
   wire [2:0] shamt      = gran ? (range_code[2] ? 3'h3 : range_code - 3'h1)
                                : range_code + 3'h3;
   wire [8:0] blocks     = 9'h001 << shamt;
   wire       in_region  = top_bot ? (blk < blocks)
                                   : (blk >= flash_otp_pkg::BLOCK_COUNT - blocks);
   wire       base_prot  = (range_code == 3'h0) ? 1'b0 : (all_code || in_region);
   wire       prot_now   = base_prot ^ cmp_q;

   // registered answer; security pages never consult it
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prot_out_q <= 1'b0;
      end else begin
         prot_out_q <= prot_now;
      end
   end

   assign o_array_protected = prot_out_q;
   assign o_busy            = busy_q;
   assign o_write_enable    = wel_q;
   assign o_otp_lock        = lock_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   property p_wp_freezes;
      @(posedge i_clock) disable iff (!i_rst_n)
      (frame_end && wp_low) |=> ($stable(prot_q) && $stable(cmp_q));
   endproperty
   a_wp_freezes: assert property (p_wp_freezes) else $error("protection changed under wp");

   property p_erase_busy;
      @(posedge i_clock) disable iff (!i_rst_n)
      erase_go |=> busy_q [*8];
   endproperty
   a_erase_busy: assert property (p_erase_busy) else $error("erase did not raise busy");

   property p_lock_sticky;
      @(posedge i_clock) disable iff (!i_rst_n)
      (lock_q != 3'h0) |=> ((lock_q & $past(lock_q)) == $past(lock_q));
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

   property p_locked_ignored;
      @(posedge i_clock) disable iff (!i_rst_n)
      (is_erase && page_hit && page_lock) |=> !busy_q;
   endproperty
   a_locked_ignored: assert property (p_locked_ignored) else $error("locked page erased");

   property p_abort_clears_wel;
      @(posedge i_clock) disable iff (!i_rst_n)
      (is_erase && byte_q != flash_otp_pkg::OTP_ADDR_BYTES) |=> (!wel_q && !busy_q);
   endproperty
   a_abort_clears_wel: assert property (p_abort_clears_wel) else $error("abort kept wel");

   property p_wren_sets;
      @(posedge i_clock) disable iff (!i_rst_n)
      op_wren |=> wel_q;
   endproperty
   a_wren_sets: assert property (p_wren_sets) else $error("write enable not latched");

   property p_code0_none;
      @(posedge i_clock) disable iff (!i_rst_n)
      (range_code == 3'h0 && !cmp_q) ##1 $stable(prot_q) |-> !o_array_protected;
   endproperty
   a_code0_none: assert property (p_code0_none) else $error("code 000 protects");

   property p_cmp_all;
      @(posedge i_clock) disable iff (!i_rst_n)
      (range_code == 3'h0 && cmp_q) ##1 ($stable(prot_q) && $stable(cmp_q)) |-> o_array_protected;
   endproperty
   a_cmp_all: assert property (p_cmp_all) else $error("complement of none not all");

   property p_release_floats;
      @(posedge i_clock) disable iff (!i_rst_n)
      i_cs_n |-> o_so_oe_n;
   endproperty
   a_release_floats: assert property (p_release_floats) else $error("output driven after release");

   c_erase:   cover property (@(posedge i_clock) disable iff (!i_rst_n) erase_go ##[1:300] nv_done);
   c_program: cover property (@(posedge i_clock) disable iff (!i_rst_n) prog_go);
   c_wp_stop: cover property (@(posedge i_clock) disable iff (!i_rst_n) is_wrsr && wp_low);
   c_read:    cover property (@(negedge i_sclk) disable iff (!i_rst_n) rd_data && drive_q);

endmodule : flash_otp_ctrl

// ### logic/flash_otp_pkg.sv
// constants shared by the protection decoder and the security-page command logic
package flash_otp_pkg;

   // command opcodes
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
   localparam logic [7:0] OP_READ_STATUS1  = 8'h05;
   localparam logic [7:0] OP_READ_STATUS2  = 8'h35;
   localparam logic [7:0] OP_OTP_ERASE     = 8'h44;
   localparam logic [7:0] OP_OTP_PROGRAM   = 8'h42;
   localparam logic [7:0] OP_OTP_READ      = 8'h48;

   // status byte 1 field positions
   localparam int S1_PROTECT   = 7;
   localparam int S1_GRAN      = 6;
   localparam int S1_TOP_BOT   = 5;
   localparam int S1_RANGE_LSB = 2;
   localparam int S1_WEL       = 1;
   localparam int S1_BUSY      = 0;
   // status byte 2 field positions
   localparam int S2_CMP       = 6;
   localparam int S2_LOCK_LSB  = 3;

   // reset values of the status fields
   localparam logic [5:0] PROT_BITS_RESET = 6'h00;
   localparam logic       CMP_RESET       = 1'b0;
   localparam logic [2:0] LOCK_RESET      = 3'h0;

   // security page addressing and frame lengths in bytes
   localparam logic [7:0] OTP_HIGH_BYTE   = 8'h00;
   localparam logic [7:0] OTP_FIRST_PAGE  = 8'h01;
   localparam logic [7:0] OTP_LAST_PAGE   = 8'h03;
   localparam logic [8:0] OTP_ADDR_BYTES  = 9'h004;
   localparam logic [8:0] OTP_DATA_FIRST  = 9'h004;
   localparam logic [8:0] OTP_READ_FIRST  = 9'h005;
   localparam logic [7:0] ERASED_BYTE     = 8'hff;

   // 4-Kbyte protection granule within the 1-Mbyte array
   localparam int         BLOCK_LSB       = 12;
   localparam logic [8:0] BLOCK_COUNT     = 9'h100;

   // timing
   localparam int CLOCK_MHZ           = 200;
   localparam int OTP_ERASE_TIME_US   = 1000;
   localparam int OTP_PROGRAM_TIME_US = 100;
   localparam int OTP_ERASE_CYCLES    = OTP_ERASE_TIME_US * CLOCK_MHZ;
   localparam int OTP_PROGRAM_CYCLES  = OTP_PROGRAM_TIME_US * CLOCK_MHZ;

   // nonvolatile operation sequencer
   typedef enum logic [1:0] {ST_IDLE, ST_APPLY, ST_WAIT} nv_state_t;

endpackage : flash_otp_pkg

// ### test/flash_otp_host.sv
// spi host model: mode 0 frames, link clock only inside frames
`timescale 1ns/1ps
module flash_otp_host (
   // frame alignment
   input  wire logic i_clock,
   // serial pins
   output      logic o_sclk,
   output      logic o_cs_n,
   output      logic o_si,
   input  wire logic i_so
);
   logic [7:0] b;
   logic [7:0] r;
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_si   = 1'b0;
   end
   // send tx bytes msb first, then clock in read bytes
   task automatic xfer(input logic [7:0] tx[$], input int nbits, output logic [7:0] rx[$]);
      rx = {};
      @(negedge i_clock);
      o_cs_n = 1'b0;
      #7;
      for (int i = 0; i < nbits; i++) begin
         b = (i / 8 < tx.size()) ? tx[i / 8] : 8'h00;
         o_si = b[7 - i % 8];
         #16 o_sclk = 1'b1;
         r = {r[6:0], i_so};
         if (i % 8 == 7 && i / 8 >= tx.size()) rx.push_back(r);
         #16 o_sclk = 1'b0;
      end
      #10 o_cs_n = 1'b1;
      // released line must not keep its last level
      o_si = ~o_si;
      #60;
   endtask : xfer
endmodule : flash_otp_host

// ### test/flash_otp_ctrl_tb_top.sv
// self-checking bench for the protection decoder and security pages
`timescale 1ns/1ps
module flash_otp_ctrl_tb_top;
   logic i_clock = 1'b0, i_rst_n = 1'b0, i_wp_n = 1'b1;
   logic sclk, cs_n, si, so, so_oe_n, prot, busy, write_enable_latch;
   logic [2:0]  lock;
   logic [19:0] check_addr = 20'h00000;
   logic [7:0]  tq[$], rq[$], mem[0:1023], s1 = 8'h00;
   logic [31:0] rs = 32'h929d;
   logic [2:0]  lk = 3'h0;
   logic        cm = 1'b0, ew = 1'b0;
   int          miscompares = 0, cmp_count = 0;
   always #2.5 i_clock = ~i_clock;
   flash_otp_ctrl #(.ERASE_CYCLES(40), .PROGRAM_CYCLES(20)) dut_u (.i_clock(i_clock),
      .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n),
      .o_so(so), .o_so_oe_n(so_oe_n), .i_check_addr(check_addr), .o_array_protected(prot),
      .o_busy(busy), .o_write_enable(write_enable_latch), .o_otp_lock(lock));
   flash_otp_host host_u (.i_clock(i_clock), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
      .i_so(so));
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs
   // model of the protected region in 4k blocks
   function automatic logic pf(logic [19:0] a);
      int r, n;
      r = s1[4:2];
      if (r == 0) n = 0;
      else if (!s1[6]) n = (r > 4) ? 256 : 8 << r;
      else n = (r > 5) ? 256 : (r > 3) ? 8 : 1 << (r - 1);
      return (s1[5] ? (a[19:12] < n) : (a[19:12] >= 256 - n)) ^ cm;
   endfunction : pf
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic run(input int n);
      host_u.xfer(tq, n, rq);
   endtask : run
   task automatic wren();
      tq = {flash_otp_pkg::OP_WRITE_ENABLE};
      run(8);
      ew = 1'b1;
      chk("wel", write_enable_latch, 1);
   endtask : wren
   task automatic wait_idle();
      logic [7:0] st;
      st = 8'h01;
      tq = {flash_otp_pkg::OP_READ_STATUS1};
      for (int i = 0; i < 40 && st[0] !== 1'b0; i++) begin
         run(16);
         st = rq[0];
      end
      chk("idle", busy, 0);
      if (busy !== 1'b0) complete_run();
      // one more read: the latch and busy bits clear on the same system clock edge
      run(16);
      chk("st1", rq[0], {s1[7:2], ew, 1'b0});
   endtask : wait_idle
   task automatic wrst(input logic [7:0] b1, input logic [7:0] b2);
      wren();
      tq = {flash_otp_pkg::OP_WRITE_STATUS, b1, b2};
      run(24);
      if (i_wp_n) begin
         s1[7:2] = b1[7:2];
         cm = b2[6];
         lk = lk | b2[5:3];
         ew = 1'b0;
      end
      chk("wel_ws", write_enable_latch, ew);
      chk("lock", lock, lk);
      tq = {flash_otp_pkg::OP_READ_STATUS2};
      run(16);
      chk("st2", rq[0], {1'b0, cm, lk, 3'h0});
   endtask : wrst
   task automatic rd(input logic [7:0] p, input logic [7:0] o, input int n);
      logic [9:0] ix;
      tq = {flash_otp_pkg::OP_OTP_READ, 8'h00, p, o, 8'h00};
      run(40 + 8 * n);
      for (int k = 0; k < n; k++) begin
         ix = {p[1:0], o} + k[9:0];
         chk("otp_rd", rq[k], mem[ix]);
      end
      chk("oe_n", so_oe_n, 1);
   endtask : rd
   task automatic prog(input logic [7:0] p, input logic [7:0] o, input logic [23:0] d);
      wren();
      tq = {flash_otp_pkg::OP_OTP_PROGRAM, 8'h00, p, o, d[23:16], d[15:8], d[7:0]};
      run(56);
      for (int k = 0; k < 3 && !lk[p - 1]; k++)
         mem[{p[1:0], o + k[7:0]}] &= d[23 - 8 * k -: 8];
      ew = 1'b0;
      wait_idle();
   endtask : prog
   task automatic erase(input logic [7:0] p, input int nb, input bit we);
      logic ok;
      if (we) wren();
      ok = ew && nb == 32 && !lk[p - 1];
      tq = {flash_otp_pkg::OP_OTP_ERASE, 8'h00, p, 8'(xs())};
      run(nb);
      chk("erase_busy", busy, ok);
      if (ok) for (int i = 0; i < 256; i++) mem[{p[1:0], i[7:0]}] = 8'hff;
      ew = 1'b0;
      wait_idle();
      chk("wel_er", write_enable_latch, 0);
   endtask : erase
   initial begin
      for (int i = 0; i < 1024; i++) mem[i] = 8'hff;
      repeat (5) @(negedge i_clock);
      i_rst_n = 1'b1;
      repeat (3) @(negedge i_clock);
      chk("lock_rst", lock, 0);
      for (int c = 0; c < 10; c++) begin
         rs = xs();
         wrst({1'b0, rs[4:0], 2'b00}, {1'b0, rs[5], 6'h00});
         for (int k = 0; k < 6; k++) begin
            @(negedge i_clock) check_addr = 20'(xs());
            @(negedge i_clock) chk("prot", prot, pf(check_addr));
         end
      end
      i_wp_n = 1'b0;
      repeat (4) @(negedge i_clock);
      wrst(8'h1c, 8'h40);
      @(negedge i_clock) check_addr = 20'h00000;
      @(negedge i_clock) chk("prot_wp", prot, pf(check_addr));
      i_wp_n = 1'b1;
      repeat (4) @(negedge i_clock);
      wrst(8'h1c, 8'h00);
      prog(2, 8'hfe, 24'h1234a5);
      rd(2, 8'hfd, 5);
      erase(2, 32, 1);
      rd(2, 8'hfe, 3);
      prog(3, 8'hff, 24'h0f0f0f);
      erase(3, 31, 1);
      erase(3, 40, 1);
      erase(3, 32, 0);
      rd(3, 8'hff, 3);
      prog(1, 8'h10, 24'h00aa55);
      wrst(8'h00, 8'h08);
      erase(1, 32, 1);
      wrst(8'h00, 8'h00);
      rd(1, 8'h10, 3);
      tq = {flash_otp_pkg::OP_OTP_READ, 8'h00, 8'h01, 8'h00, 8'h00};
      run(44);
      chk("oe_mid", so_oe_n, 1);
      complete_run();
   end
endmodule : flash_otp_ctrl_tb_top
